// file: logic/energy_noload_accum.sv
`timescale 1ns/1ns
`default_nettype none
`include "energy_cfg_params.svh"

module energy_noload_accum
  import energy_cfg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire power_sample_t sample,
  input wire logic fault_mode,
  input wire logic tamper_channel_b,
  input wire logic pulse_src_reactive,
  output accum_out_t accum,
  output pulse_out_t pulse,
  output logic reactive_freq_comp_off,
  output logic irq
);

  function automatic pwr_t sat_neg(input pwr_t x);
    // The most negative code has no positive twin, so it clamps.
    sat_neg = (x == 24'h800000) ? 24'h7fffff : -x;
  endfunction

  function automatic pwr_t sat_abs(input pwr_t x);
    sat_abs = x[23] ? sat_neg(x) : x;
  endfunction

  logic [7:0] nl_ff;
  logic [6:0] acc_ff;
  logic [2:0] status_ff;
  logic [2:0] mask_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic act_prev_neg_ff;
  logic react_prev_neg_ff;
  logic fault_prev_ff;
  accum_out_t accum_ff;
  pulse_out_t pulse_ff;
  logic freq_comp_off_ff;
  logic irq_ff;

  // APB decode. Every access takes exactly one wait-free access cycle.
  wire logic [5:0] idx = paddr[7:2];
  wire logic setup = psel && !penable;
  wire logic done = psel && penable && pready_ff;
  wire logic hit_nl = (idx == `REG_NO_LOAD_IDX);
  wire logic hit_acc = (idx == `REG_ACCUM_IDX);
  wire logic hit_st = (idx == `REG_STATUS_IDX);
  wire logic hit_mask = (idx == `REG_MASK_IDX);
  wire logic addr_ok = (paddr[1:0] == 2'b00) && (hit_nl || hit_acc || hit_st || hit_mask);
  wire logic wr = done && pwrite && !pslverr_ff;
  wire logic rd_st_done = done && !pwrite && !pslverr_ff && hit_st;

  // Channel bit is live state, never stored, so writes to it are dropped.
  wire logic [7:0] acc_view = {tamper_channel_b, acc_ff};
  wire logic [31:0] rd_mux =
    !addr_ok ? 32'h0 :
    hit_nl ? {24'h0, nl_ff} :
    hit_acc ? {24'h0, acc_view} :
    hit_st ? {29'h0, status_ff} : {29'h0, mask_ff};

  wire logic [7:0] nxt_nl = (wr && hit_nl) ? pwdata[7:0] : nl_ff;
  wire logic [6:0] nxt_acc = (wr && hit_acc) ? pwdata[6:0] : acc_ff;
  wire logic [2:0] nxt_mask = (wr && hit_mask) ? pwdata[2:0] : mask_ff;
  wire logic [31:0] nxt_prdata = (setup && !pwrite) ? rd_mux : 32'h0;

  // No-load comparators; the rms current path borrows the apparent field.
  logic act_idle;
  logic react_idle;
  logic app_idle;
  logic irms_idle_raw;

  noload_gate #(.APPARENT_TABLE(1'b0)) u_act_gate (
    .code(nl_ff[`NL_ACT_HI:`NL_ACT_LO]),
    .level(sample.active),
    .idle(act_idle)
  );

  noload_gate #(.APPARENT_TABLE(1'b0)) u_react_gate (
    .code(nl_ff[`NL_REACT_HI:`NL_REACT_LO]),
    .level(sample.reactive),
    .idle(react_idle)
  );

  noload_gate #(.APPARENT_TABLE(1'b1)) u_app_gate (
    .code(nl_ff[`NL_APP_HI:`NL_APP_LO]),
    .level(sample.apparent),
    .idle(app_idle)
  );

  noload_gate #(.APPARENT_TABLE(1'b1)) u_irms_gate (
    .code(nl_ff[`NL_APP_HI:`NL_APP_LO]),
    .level(sample.irms),
    .idle(irms_idle_raw)
  );

  wire logic irms_idle = nl_ff[`NL_IRMS_EN] && irms_idle_raw;

  // Accumulation mode shaping.
  wire logic act_neg = sample.active[23];
  wire logic react_neg = sample.reactive[23];
  wire pwr_t act_shaped =
    acc_ff[`ACC_ACT_ABS] ? sat_abs(sample.active) :
    (acc_ff[`ACC_ACT_POS] && act_neg) ? 24'h0 : sample.active;
  wire pwr_t react_shaped =
    acc_ff[`ACC_REACT_ABS] ? sat_abs(sample.reactive) :
    (acc_ff[`ACC_REACT_STEER] && act_neg) ? sat_neg(sample.reactive) :
    sample.reactive;
  wire pwr_t act_val = act_idle ? 24'h0 : act_shaped;
  wire pwr_t react_val = react_idle ? 24'h0 : react_shaped;
  wire pwr_t app_val = app_idle ? 24'h0 : sample.apparent;

  accum_out_t nxt_accum;
  pulse_out_t nxt_pulse;
  always_comb begin
    nxt_accum = accum_ff;
    nxt_accum.active_en = sample.valid && !act_idle;
    nxt_accum.reactive_en = sample.valid && !react_idle;
    nxt_accum.apparent_en = sample.valid && !app_idle;
    nxt_accum.irms_en = sample.valid && !irms_idle;
    nxt_pulse = pulse_ff;
    nxt_pulse.en = 1'b0;
    if (sample.valid) begin
      nxt_accum.active = act_val;
      nxt_accum.reactive = react_val;
      nxt_accum.apparent = app_val;
      // The pulse path sees the same shaping as the energy registers.
      nxt_pulse.en = pulse_src_reactive ? !react_idle : !act_idle;
      nxt_pulse.value = pulse_src_reactive ? react_val : act_val;
    end
  end

  // Sign and fault events. Zero counts as positive.
  wire logic act_evt = sample.valid && (act_neg != act_prev_neg_ff) &&
                       (act_neg == !acc_ff[`ACC_ACT_EDGE]);
  wire logic react_evt = sample.valid && (react_neg != react_prev_neg_ff) &&
                         (react_neg == !acc_ff[`ACC_REACT_EDGE]);
  wire logic fault_evt = (fault_mode != fault_prev_ff) &&
                         (fault_mode == !acc_ff[`ACC_FAULT_EDGE]);
  wire logic [2:0] evt = {fault_evt, react_evt, act_evt};

  // A read clears only the bits it returned, and a new event wins the same cycle.
  wire logic [2:0] st_clr = rd_st_done ? prdata_ff[2:0] : 3'h0;
  wire logic [2:0] nxt_status = (status_ff & ~st_clr) | evt;
  wire logic nxt_irq = |(nxt_status & nxt_mask);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nl_ff <= `NO_LOAD_RESET;
      acc_ff <= `ACCUM_RESET;
      mask_ff <= `MASK_RESET;
      status_ff <= `STATUS_RESET;
    end else begin
      nl_ff <= nxt_nl;
      acc_ff <= nxt_acc;
      mask_ff <= nxt_mask;
      status_ff <= nxt_status;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff <= nxt_prdata;
      pready_ff <= setup;
      pslverr_ff <= setup && !addr_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_prev_neg_ff <= 1'b0;
      react_prev_neg_ff <= 1'b0;
      fault_prev_ff <= 1'b0;
    end else begin
      act_prev_neg_ff <= sample.valid ? act_neg : act_prev_neg_ff;
      react_prev_neg_ff <= sample.valid ? react_neg : react_prev_neg_ff;
      fault_prev_ff <= fault_mode;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accum_ff <= '0;
      pulse_ff <= '0;
      freq_comp_off_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      accum_ff <= nxt_accum;
      pulse_ff <= nxt_pulse;
      freq_comp_off_ff <= nl_ff[`NL_FREQ_COMP_OFF];
      irq_ff <= nxt_irq;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign accum = accum_ff;
  assign pulse = pulse_ff;
  assign reactive_freq_comp_off = freq_comp_off_ff;
  assign irq = irq_ff;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_freq_comp_out: assert property (
    wr && hit_nl |=> ##1 reactive_freq_comp_off == $past(pwdata[7], 2))
    else $error("frequency compensation disable did not follow the write");

  a_irms_gate: assert property (
    sample.valid && nl_ff[`NL_IRMS_EN] && irms_idle_raw |=> !accum.irms_en)
    else $error("rms current passed while below its no-load level");

  a_app_lvl1: assert property (
    sample.valid && nl_ff[5:4] == 2'b01 && sample.apparent >= 0 &&
    sample.apparent < 24'sh0009d4 |=> !accum.apparent_en)
    else $error("apparent power below coarse threshold was accumulated");

  a_act_noload: assert property (
    sample.valid && act_idle && !pulse_src_reactive |=>
    !accum.active_en && !pulse.en && accum.active == 24'h0)
    else $error("idle active power still accumulated or pulsed");

  a_react_lvl3: assert property (
    sample.valid && nl_ff[3:2] == 2'b11 && sample.reactive == 24'sh000100 |=>
    !accum.reactive_en)
    else $error("reactive power below finest threshold was accumulated");

  a_chan_read: assert property (
    setup && !pwrite && addr_ok && hit_acc |=>
    pready && prdata[7] == $past(tamper_channel_b))
    else $error("channel indicator read back wrong");

  a_fault_edge: assert property (
    $rose(fault_mode) && !acc_ff[`ACC_FAULT_EDGE] |=>
    status_ff[`ST_FAULT] && (irq || !mask_ff[`ST_FAULT]))
    else $error("fault entry did not raise its flag");

  a_fault_return: assert property (
    $fell(fault_mode) && acc_ff[`ACC_FAULT_EDGE] |=> status_ff[`ST_FAULT])
    else $error("return to normal mode did not raise the fault flag");

  a_react_edge: assert property (
    sample.valid && react_neg && !react_prev_neg_ff && !acc_ff[`ACC_REACT_EDGE] |=>
    status_ff[`ST_REACT_SIGN])
    else $error("reactive sign fall not flagged");

  a_react_rise: assert property (
    sample.valid && !react_neg && react_prev_neg_ff && acc_ff[`ACC_REACT_EDGE] |=>
    status_ff[`ST_REACT_SIGN])
    else $error("reactive sign rise not flagged");

  a_act_edge: assert property (
    sample.valid && !act_neg && act_prev_neg_ff && acc_ff[`ACC_ACT_EDGE] |=>
    status_ff[`ST_ACT_SIGN])
    else $error("active sign rise not flagged");

  a_act_fall: assert property (
    sample.valid && act_neg && !act_prev_neg_ff && !acc_ff[`ACC_ACT_EDGE] |=>
    status_ff[`ST_ACT_SIGN])
    else $error("active sign fall not flagged");

  a_act_lvl1: assert property (
    sample.valid && nl_ff[1:0] == 2'b01 && sample.active >= 0 &&
    sample.active < 24'sh0004ea |=> !accum.active_en)
    else $error("active power below its threshold was accumulated");

  a_act_at_lvl: assert property (
    sample.valid && nl_ff[1:0] == 2'b01 && sample.active == 24'sh0004ea |=> accum.active_en)
    else $error("active power at its threshold was dropped");

  a_app_off: assert property (
    sample.valid && nl_ff[5:4] == 2'b00 |=> accum.apparent_en)
    else $error("apparent power dropped with detection disabled");

  a_bad_addr: assert property (
    setup && !addr_ok |=> pready && pslverr && prdata == 32'h0)
    else $error("unmapped access was not refused");

  a_react_abs: assert property (
    sample.valid && acc_ff[`ACC_REACT_ABS] |=> !accum.reactive[23])
    else $error("absolute reactive accumulation went negative");

  a_react_steer: assert property (
    sample.valid && acc_ff[`ACC_REACT_STEER] && !acc_ff[`ACC_REACT_ABS] && act_neg &&
    !react_idle && sample.reactive > 0 |=> accum.reactive < 0)
    else $error("reactive sign not inverted for negative active power");

  a_pulse_route: assert property (
    sample.valid && pulse_src_reactive |=> pulse.value == accum.reactive)
    else $error("reactive-routed pulse disagrees with reactive energy");

  a_act_posonly: assert property (
    sample.valid && acc_ff[`ACC_ACT_POS] && !acc_ff[`ACC_ACT_ABS] && act_neg |=>
    accum.active == 24'h0)
    else $error("negative active power accumulated in positive-only mode");

  a_act_abs: assert property (
    sample.valid && acc_ff[`ACC_ACT_ABS] && !act_idle && act_neg |=>
    accum.active > 0)
    else $error("absolute active accumulation lost a negative sample");

  a_irq_level: assert property (
    ##1 irq == |(status_ff & mask_ff))
    else $error("interrupt level disagrees with masked status");

endmodule
`default_nettype wire

// file: logic/energy_cfg_params.svh
`ifndef ENERGY_CFG_PARAMS_SVH
`define ENERGY_CFG_PARAMS_SVH

// Register indices; the APB byte address is four times the index.
`define REG_NO_LOAD_IDX 6'h0e
`define REG_ACCUM_IDX 6'h0f
`define REG_STATUS_IDX 6'h10
`define REG_MASK_IDX 6'h11

`define NO_LOAD_RESET 8'h00
`define ACCUM_RESET 7'h00
`define STATUS_RESET 3'h0
`define MASK_RESET 3'h0

// Field positions of no_load_config.
`define NL_FREQ_COMP_OFF 7
`define NL_IRMS_EN 6
`define NL_APP_HI 5
`define NL_APP_LO 4
`define NL_REACT_HI 3
`define NL_REACT_LO 2
`define NL_ACT_HI 1
`define NL_ACT_LO 0

// Field positions of accumulation_config.
`define ACC_CHANNEL 7
`define ACC_FAULT_EDGE 6
`define ACC_REACT_EDGE 5
`define ACC_ACT_EDGE 4
`define ACC_REACT_ABS 3
`define ACC_REACT_STEER 2
`define ACC_ACT_POS 1
`define ACC_ACT_ABS 0

// Status and mask bit positions.
`define ST_ACT_SIGN 0
`define ST_REACT_SIGN 1
`define ST_FAULT 2

// Thresholds in parts per million of full scale.
`define FULL_SCALE 48'h7fffff
`define PPM_DIV 48'hf4240
`define THR_0030_PPM 48'h12c
`define THR_0015_PPM 48'h96
`define THR_00075_PPM 48'h4b
`define THR_00037_PPM 48'h25

`endif

// file: logic/energy_cfg_pkg.sv
package energy_cfg_pkg;

  typedef logic signed [23:0] pwr_t;

  typedef enum logic [1:0] {
    NL_OFF = 2'b00,
    NL_LVL1 = 2'b01,
    NL_LVL2 = 2'b10,
    NL_LVL3 = 2'b11
  } nl_code_t;

  typedef struct packed {
    logic valid;
    pwr_t active;
    pwr_t reactive;
    pwr_t apparent;
    pwr_t irms;
  } power_sample_t;

  typedef struct packed {
    logic active_en;
    pwr_t active;
    logic reactive_en;
    pwr_t reactive;
    logic apparent_en;
    pwr_t apparent;
    logic irms_en;
  } accum_out_t;

  typedef struct packed {
    logic en;
    pwr_t value;
  } pulse_out_t;

endpackage

// file: logic/noload_gate.sv
`timescale 1ns/1ns
`default_nettype none
`include "energy_cfg_params.svh"

module noload_gate
  import energy_cfg_pkg::*;
#(
  parameter bit APPARENT_TABLE = 1'b0
) (
  input wire logic [1:0] code,
  input wire pwr_t level,
  output logic idle
);

  localparam logic [47:0] THR_0030 = `FULL_SCALE * `THR_0030_PPM / `PPM_DIV;
  localparam logic [47:0] THR_0015 = `FULL_SCALE * `THR_0015_PPM / `PPM_DIV;
  localparam logic [47:0] THR_00075 = `FULL_SCALE * `THR_00075_PPM / `PPM_DIV;
  localparam logic [47:0] THR_00037 = `FULL_SCALE * `THR_00037_PPM / `PPM_DIV;

  wire logic signed [24:0] wide = {level[23], level};
  wire logic [24:0] mag = wide[24] ? 25'(-wide) : 25'(wide);
  // The apparent table sits one step coarser than the active/reactive one.
  wire logic [47:0] thr =
    (code == NL_LVL1) ? (APPARENT_TABLE ? THR_0030 : THR_0015) :
    (code == NL_LVL2) ? (APPARENT_TABLE ? THR_0015 : THR_00075) :
    (code == NL_LVL3) ? (APPARENT_TABLE ? THR_00075 : THR_00037) : 48'h0;

  assign idle = (code != NL_OFF) && ({23'h0, mag} < thr);

endmodule
`default_nettype wire

// file: bench/energy_noload_accum_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "energy_cfg_params.svh"

module energy_noload_accum_tb_top import energy_cfg_pkg::*;;
  localparam logic [7:0] A_NL = {`REG_NO_LOAD_IDX, 2'b00};
  localparam logic [7:0] A_ACC = {`REG_ACCUM_IDX, 2'b00};
  localparam logic [7:0] A_ST = {`REG_STATUS_IDX, 2'b00};
  localparam logic [7:0] A_MSK = {`REG_MASK_IDX, 2'b00};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  power_sample_t sample = '0;
  logic fault_mode = 1'b0;
  logic tamper_channel_b = 1'b0;
  logic pulse_src_reactive = 1'b0;
  accum_out_t accum;
  pulse_out_t pulse;
  logic reactive_freq_comp_off;
  logic irq;
  logic [31:0] rd;
  logic er;
  logic [7:0] nl_cfg = 8'h00;
  logic [7:0] acc_cfg = 8'h00;
  int n_fail = 0;
  int comparisons = 0;

  energy_noload_accum i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample(sample), .fault_mode(fault_mode), .tamper_channel_b(tamper_channel_b),
    .pulse_src_reactive(pulse_src_reactive), .accum(accum), .pulse(pulse),
    .reactive_freq_comp_off(reactive_freq_comp_off), .irq(irq)
  );

  always #50 pclk = ~pclk;

  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_pwr(input pwr_t g, input pwr_t e);
    chk32({8'h00, g}, {8'h00, e});
  endtask

  task automatic chk_bit(input logic g, input logic e);
    chk32({31'h0, g}, {31'h0, e});
  endtask

  function automatic pwr_t mag(input pwr_t x);
    return (x < 0) ? -x : x;
  endfunction

  // Thresholds are whole counts of full scale, rounded down.
  function automatic pwr_t thr(input logic [1:0] c, input logic app);
    if (c == 2'd1) return app ? 24'h9d4 : 24'h4ea;
    if (c == 2'd2) return app ? 24'h4ea : 24'h275;
    return app ? 24'h275 : 24'h136;
  endfunction

  function automatic logic idle(input logic [1:0] c, input logic app, input pwr_t x);
    return (c != 2'd0) && (mag(x) < thr(c, app));
  endfunction

  // Small magnitudes dominate so that thresholds are crossed often.
  function automatic pwr_t rnd();
    pwr_t m;
    m = ($urandom_range(0, 3) == 0) ? 24'($urandom_range(0, 24'h7ffff0)) :
        24'($urandom_range(0, 24'hbb8));
    return ($urandom_range(0, 1) == 1) ? -m : m;
  endfunction

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait length is assumed; a slave that never answers is caught by the watchdog.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    chk_bit(pready, 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic cfg(input logic [7:0] nl, input logic [7:0] acc);
    nl_cfg = nl;
    acc_cfg = acc;
    apb(1'b1, A_NL, {24'h0, nl});
    apb(1'b1, A_ACC, {24'h0, acc});
    apb(1'b0, A_NL, 32'h0);
    chk32(rd, {24'h0, nl});
    chk_bit(er, 1'b0);
    apb(1'b0, A_ACC, 32'h0);
    chk32(rd, {24'h0, tamper_channel_b, acc[6:0]});
    chk_bit(er, 1'b0);
    chk_bit(reactive_freq_comp_off, nl[7]);
  endtask

  task automatic send(input pwr_t a, input pwr_t r, input pwr_t s, input pwr_t i);
    logic ia, ir, is, ii;
    pwr_t ea, ex;
    ia = idle(nl_cfg[1:0], 1'b0, a);
    ir = idle(nl_cfg[3:2], 1'b0, r);
    is = idle(nl_cfg[5:4], 1'b1, s);
    ii = nl_cfg[6] && idle(nl_cfg[5:4], 1'b1, i);
    ea = ia ? 24'h0 : acc_cfg[0] ? mag(a) : (acc_cfg[1] && a < 0) ? 24'h0 : a;
    ex = ir ? 24'h0 : acc_cfg[3] ? mag(r) : (acc_cfg[2] && a < 0) ? -r : r;
    sample <= '{valid: 1'b1, active: a, reactive: r, apparent: s, irms: i};
    @(posedge pclk);
    sample.valid <= 1'b0;
    #1;
    chk_pwr(accum.active, ea);
    chk_pwr(accum.reactive, ex);
    chk_pwr(accum.apparent, is ? 24'h0 : s);
    if (!(acc_cfg[1] && !acc_cfg[0] && a < 0)) chk_bit(accum.active_en, !ia);
    chk_bit(accum.reactive_en, !ir);
    chk_bit(accum.apparent_en, !is);
    chk_bit(accum.irms_en, !ii);
    chk_pwr(pulse.value, pulse_src_reactive ? ex : ea);
    chk_bit(pulse.en, pulse_src_reactive ? !ir : !ia);
    @(posedge pclk);
  endtask

  task automatic final_report;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    final_report;
  end

  initial begin
    pwr_t p, t, u;
    void'($urandom(32'h2afb7de4));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, A_NL + 8'(4 * k), 32'h0);
      chk32(rd, 32'h0);
    end
    apb(1'b0, 8'h48, 32'h0);
    chk_bit(er, 1'b1);
    chk32(rd, 32'h0);
    apb(1'b1, 8'h39, 32'hff);
    chk_bit(er, 1'b1);
    apb(1'b0, A_NL, 32'h0);
    chk32(rd, 32'h0);
    // Every threshold code is probed exactly at and just below its level.
    for (int c = 1; c < 4; c++) begin
      cfg({2'b01, 2'(c), 2'(c), 2'(c)}, 8'h00);
      t = thr(2'(c), 1'b0);
      u = thr(2'(c), 1'b1);
      send(t, -(t - 24'h1), u - 24'h1, u);
      send(-(t - 24'h1), t, -u, -(u - 24'h1));
    end
    for (int n = 0; n < 40; n++) begin
      tamper_channel_b <= 1'($urandom_range(0, 1));
      pulse_src_reactive <= 1'($urandom_range(0, 1));
      cfg(8'($urandom), 8'($urandom));
      repeat (3) send(rnd(), rnd(), rnd(), rnd());
    end
    apb(1'b1, A_MSK, 32'h7);
    for (int sel = 0; sel < 2; sel++) begin
      cfg(8'h00, {2'b00, 1'(sel), 1'(sel), 4'h0});
      p = (sel == 1) ? -24'sh1000 : 24'sh1000;
      send(p, p, p, p);
      apb(1'b0, A_ST, 32'h0);
      send(-p, -p, p, p);
      chk_bit(irq, 1'b1);
      apb(1'b0, A_ST, 32'h0);
      chk32(rd, 32'h3);
      chk_bit(irq, 1'b0);
      send(p, p, p, p);
      apb(1'b0, A_ST, 32'h0);
      chk32(rd, 32'h0);
    end
    for (int sel = 0; sel < 2; sel++) begin
      cfg(8'h00, {1'b0, 1'(sel), 6'h00});
      fault_mode <= 1'b1;
      repeat (2) @(posedge pclk);
      chk_bit(irq, sel == 0);
      apb(1'b0, A_ST, 32'h0);
      chk32(rd, (sel == 0) ? 32'h4 : 32'h0);
      fault_mode <= 1'b0;
      repeat (2) @(posedge pclk);
      apb(1'b0, A_ST, 32'h0);
      chk32(rd, (sel == 1) ? 32'h4 : 32'h0);
    end
    apb(1'b1, A_MSK, 32'h0);
    fault_mode <= 1'b1;
    @(posedge pclk);
    fault_mode <= 1'b0;
    repeat (2) @(posedge pclk);
    chk_bit(irq, 1'b0);
    apb(1'b0, A_ST, 32'h0);
    chk32(rd, 32'h4);
    final_report;
  end
endmodule
`default_nettype wire
